//--- core/wdt_map.svh
// Register indices, field positions, reset values and timing counts
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH
// ---------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------------
`define WDT_IDX_CONTROL   10'h0a7
`define WDT_IDX_FEED      10'h0a8
`define WDT_IDX_IRQ_STAT  10'h0a9
`define WDT_IDX_IRQ_MASK  10'h0aa
// ---------------------------------------------------------------------
// Control register fields and values
// ---------------------------------------------------------------------
`define WDT_BIT_OVF       5
`define WDT_BIT_RUN       4
`define WDT_BIT_CLKSEL    3
`define WDT_RATE_MSB      2
`define WDT_CTRL_RST_OFF  8'h00
`define WDT_CTRL_RST_ON   8'h10
`define WDT_CTRL_WD_FEED_REG    8'h30
// ---------------------------------------------------------------------
// Feed sequence, interrupt bits, clocking
// ---------------------------------------------------------------------
`define WDT_FEED_FIRST    8'h1e
`define WDT_FEED_SECOND   8'he1
`define WDT_IRQ_TMR       0
`define WDT_IRQ_FEEDERR   1
`define WDT_IRQ_W         2
`define WDT_CPU_DIV_LAST  3'h5
`define WDT_TIMEOUT_BASE  8192
`define WDT_CLK_PERIOD_NS 100
`define WDT_RST_TIME_NS   1000
`define WDT_RST_CYCLES \
  ((`WDT_RST_TIME_NS + `WDT_CLK_PERIOD_NS - 1) / `WDT_CLK_PERIOD_NS)
`endif

//--- core/wdt_pkg.sv
// Types shared by the watchdog interval timer
package wdt_pkg;
  // Watchdog reset sequencer states
  typedef enum logic [2:0] {
    WDT_ST_IDLE = 3'b001,
    WDT_ST_OSC  = 3'b010,
    WDT_ST_HOLD = 3'b100
  } wdt_rst_state_type;
  typedef logic [7:0] wdt_byte_type;
endpackage

//--- core/wdt_timeout_ctr.sv
// Timeout counter with eight doubling rate selections
`timescale 1ns/1ps
`default_nettype none
module wdt_timeout_ctr #(
  parameter int CNT_W = 21,
  parameter int BASE  = 8192
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       tick_in,
  input  wire logic       run_in,
  input  wire logic       restart_in,
  input  wire logic [2:0] rate_in,
  output logic            expired_out
);
  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] count_q;

  // Timeout length doubles with each rate code
  assign limit = CNT_W'(BASE) << rate_in;

  // Count ticks; a lowered rate expires on the next tick rather than wrapping
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_q     <= '0;
      expired_out <= 1'b0;
    end else begin
      expired_out <= 1'b0;
      if (restart_in) begin
        count_q <= '0;
      end else if (run_in && tick_in) begin
        if (count_q >= limit - 1'b1) begin
          count_q     <= '0;
          expired_out <= 1'b1;
        end else begin
          count_q <= count_q + 1'b1;
        end
      end
    end
  end
endmodule // wdt_timeout_ctr
`default_nettype wire

//--- core/wdt_top.sv
// Watchdog interval timer with Wishbone register access
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"
module wdt_top #(
  parameter int TIMEOUT_BASE = `WDT_TIMEOUT_BASE,
  parameter int CNT_W        = 21
) (
  input  wire logic        CLK_IN,
  input  wire logic        RESET_IN,
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [11:0] WB_ADR_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic [31:0] WB_DAT_IN,
  output logic      [31:0] WB_DAT_OUT,
  output logic             WB_ACK_OUT,
  input  wire logic        WD_ENABLE_CFG_BIT_IN,
  input  wire logic        RC_TICK_IN,
  input  wire logic        POWER_DOWN_IN,
  input  wire logic        OSC_STABLE_IN,
  output logic             CHIP_RESET_OUT,
  output logic             OSC_START_OUT,
  output logic             IRQ_OUT
);
  localparam int RST_CYC = `WDT_RST_CYCLES;
  // Named copies so the reset values can be sliced field by field
  localparam logic [7:0] CTRL_OFF = `WDT_CTRL_RST_OFF;
  localparam logic [7:0] CTRL_WD  = `WDT_CTRL_WD_FEED_REG;

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  wdt_pkg::wdt_rst_state_type st_q;
  wdt_pkg::wdt_rst_state_type st_d;
  wdt_pkg::wdt_byte_type      wr_byte;
  wdt_pkg::wdt_byte_type      ctrl_rd;
  logic                       cfg_q;
  logic                       cfg_valid_q;
  logic                       ack_q;
  logic [31:0]                dat_q;
  logic                       wr_go;
  logic                       ovf_q;
  logic                       run_q;
  logic                       clksel_q;
  logic [2:0]                 rate_q;
  logic                       lock_q;
  logic                       armed_q;
  logic                       feed_ok;
  logic                       feed_bad;
  logic [2:0]                 div_q;
  logic                       div_tick;
  logic                       run_eff;
  logic                       clk_eff;
  logic                       tick;
  logic                       expired;
  logic                       wd_fire;
  logic                       tmr_ovf;
  logic                       restart;
  logic [3:0]                 hold_q;
  logic [`WDT_IRQ_W-1:0]      stat_q;
  logic [`WDT_IRQ_W-1:0]      stat_d;
  logic [`WDT_IRQ_W-1:0]      mask_q;
  logic [`WDT_IRQ_W-1:0]      mask_d;
  logic                       rst_q;
  logic                       osc_q;
  logic                       irq_q;

  // Address decode shared by the read and write paths
  function automatic logic is_reg(input logic [11:0] adr,
                                  input logic [9:0]  idx);
    is_reg = (adr[11:2] == idx);
  endfunction

  // ------------------------------------------------------------------
  // Configuration strap
  // ------------------------------------------------------------------
  // Caught on the first edge after release, never inside the reset
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      cfg_q       <= 1'b0;
      cfg_valid_q <= 1'b0;
    end else if (!cfg_valid_q) begin
      cfg_q       <= WD_ENABLE_CFG_BIT_IN;
      cfg_valid_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Wishbone slave
  // ------------------------------------------------------------------
  // One wait state; writes act on the edge where ack is sampled
  assign wr_go   = WB_CYC_IN & WB_STB_IN & WB_WE_IN & ack_q & WB_SEL_IN[0];
  assign wr_byte = WB_DAT_IN[7:0];

  // Reserved bits 7 and 6 are not stored and read as zero
  always_comb begin
    ctrl_rd                  = 8'h00;
    ctrl_rd[`WDT_BIT_OVF]    = ovf_q;
    ctrl_rd[`WDT_BIT_RUN]    = cfg_q | run_q;
    ctrl_rd[`WDT_BIT_CLKSEL] = ~cfg_q & clksel_q;
    ctrl_rd[`WDT_RATE_MSB:0] = rate_q;
  end

  // Ack and registered read data; unmapped addresses read zero
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= WB_CYC_IN & WB_STB_IN & ~ack_q;
      if (WB_CYC_IN && WB_STB_IN && !ack_q) begin
        if (is_reg(WB_ADR_IN, `WDT_IDX_CONTROL)) begin
          dat_q <= {24'h00_0000, ctrl_rd};
        end else if (is_reg(WB_ADR_IN, `WDT_IDX_IRQ_STAT)) begin
          dat_q <= {30'h0, stat_q};
        end else if (is_reg(WB_ADR_IN, `WDT_IDX_IRQ_MASK)) begin
          dat_q <= {30'h0, mask_q};
        end else begin
          dat_q <= 32'h0000_0000;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Feed sequence
  // ------------------------------------------------------------------
  // Other accesses between the two writes leave the first one armed
  assign feed_ok  = wr_go & is_reg(WB_ADR_IN, `WDT_IDX_FEED) & armed_q &
                    (wr_byte == `WDT_FEED_SECOND);
  assign feed_bad = wr_go & is_reg(WB_ADR_IN, `WDT_IDX_FEED) &
                    (wr_byte != `WDT_FEED_FIRST) & ~feed_ok;

  // A wrong byte disarms and flags FEEDERR; the count is left alone
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      armed_q <= 1'b0;
    end else if (wr_go && is_reg(WB_ADR_IN, `WDT_IDX_FEED)) begin
      armed_q <= (wr_byte == `WDT_FEED_FIRST);
    end
  end

  // ------------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------------
  // Watchdog reset loads 30h and reopens the one-shot write
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      {ovf_q, run_q, clksel_q, rate_q} <= CTRL_OFF[`WDT_BIT_OVF:0];
      lock_q   <= 1'b0;
    end else if (wd_fire) begin
      {ovf_q, run_q, clksel_q, rate_q} <= CTRL_WD[`WDT_BIT_OVF:0];
      lock_q   <= 1'b0;
    end else begin
      if (wr_go && is_reg(WB_ADR_IN, `WDT_IDX_CONTROL)) begin
        if (cfg_q) begin
          if (!lock_q) begin
            rate_q <= wr_byte[`WDT_RATE_MSB:0];
            lock_q <= 1'b1;
          end
        end else begin
          ovf_q    <= wr_byte[`WDT_BIT_OVF];
          run_q    <= wr_byte[`WDT_BIT_RUN];
          clksel_q <= wr_byte[`WDT_BIT_CLKSEL];
          rate_q   <= wr_byte[`WDT_RATE_MSB:0];
        end
      end
      // Overflow set beats both a feed and a software clear
      if (feed_ok) begin
        ovf_q <= 1'b0;
      end
      if (tmr_ovf) begin
        ovf_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Clock source and counter
  // ------------------------------------------------------------------
  // CPU clock divided by six
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      div_q <= 3'h0;
    end else if (div_q == `WDT_CPU_DIV_LAST) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end
  assign div_tick = (div_q == `WDT_CPU_DIV_LAST);

  // Watchdog mode forces RC source and run; counter idle during resets
  assign clk_eff = ~cfg_q & clksel_q;
  assign run_eff = cfg_valid_q & (cfg_q | run_q) &
                   (st_q == wdt_pkg::WDT_ST_IDLE);
  assign tick    = clk_eff ? div_tick : RC_TICK_IN;
  assign restart = feed_ok | (st_q != wdt_pkg::WDT_ST_IDLE);

  wdt_timeout_ctr #(
    .CNT_W (CNT_W),
    .BASE  (TIMEOUT_BASE)
  ) u_ctr (
    .clk_in      (CLK_IN),
    .rst_in      (RESET_IN),
    .tick_in     (tick),
    .run_in      (run_eff),
    .restart_in  (restart),
    .rate_in     (rate_q),
    .expired_out (expired)
  );

  // Expiry means a chip reset in watchdog mode, an interrupt otherwise
  assign wd_fire = expired & cfg_q & (st_q == wdt_pkg::WDT_ST_IDLE);
  assign tmr_ovf = expired & ~cfg_q;

  // ------------------------------------------------------------------
  // Watchdog reset sequencer
  // ------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      wdt_pkg::WDT_ST_IDLE: begin
        if (wd_fire) begin
          st_d = POWER_DOWN_IN ? wdt_pkg::WDT_ST_OSC
                               : wdt_pkg::WDT_ST_HOLD;
        end
      end
      wdt_pkg::WDT_ST_OSC: begin
        if (OSC_STABLE_IN) begin
          st_d = wdt_pkg::WDT_ST_HOLD;
        end
      end
      wdt_pkg::WDT_ST_HOLD: begin
        if (hold_q == 4'(RST_CYC - 1)) begin
          st_d = wdt_pkg::WDT_ST_IDLE;
        end
      end
      default: begin
        st_d = wdt_pkg::WDT_ST_IDLE;
      end
    endcase
  end

  // Reset stays on while the oscillator starts, then one microsecond
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      st_q   <= wdt_pkg::WDT_ST_IDLE;
      hold_q <= 4'h0;
      rst_q  <= 1'b0;
      osc_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      hold_q <= (st_q == wdt_pkg::WDT_ST_HOLD) ? hold_q + 4'h1 : 4'h0;
      rst_q  <= (st_d != wdt_pkg::WDT_ST_IDLE);
      osc_q  <= (st_d == wdt_pkg::WDT_ST_OSC);
    end
  end

  // ------------------------------------------------------------------
  // Interrupt status and mask
  // ------------------------------------------------------------------
  // Write one to clear; a set in the same cycle wins
  always_comb begin
    stat_d = stat_q;
    mask_d = mask_q;
    if (wr_go && is_reg(WB_ADR_IN, `WDT_IDX_IRQ_STAT)) begin
      stat_d = stat_q & ~WB_DAT_IN[`WDT_IRQ_W-1:0];
    end
    if (wr_go && is_reg(WB_ADR_IN, `WDT_IDX_IRQ_MASK)) begin
      mask_d = WB_DAT_IN[`WDT_IRQ_W-1:0];
    end
    stat_d[`WDT_IRQ_TMR]     = stat_d[`WDT_IRQ_TMR] | tmr_ovf;
    stat_d[`WDT_IRQ_FEEDERR] = stat_d[`WDT_IRQ_FEEDERR] | feed_bad;
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      stat_q <= '0;
      mask_q <= '0;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q  <= |(stat_d & mask_d);
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign WB_ACK_OUT     = ack_q;
  assign WB_DAT_OUT     = dat_q;
  assign CHIP_RESET_OUT = rst_q;
  assign OSC_START_OUT  = osc_q;
  assign IRQ_OUT        = irq_q;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  logic [4:0] hold_seen_q;
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      hold_seen_q <= 5'h00;
    end else begin
      hold_seen_q <= rst_q && !osc_q ? hold_seen_q + 5'h01 : 5'h00;
    end
  end

  a_rst_hold_len:
  assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    $fell(rst_q) |-> hold_seen_q == 5'(RST_CYC))
  else $error("watchdog reset length wrong");
  a_wd_fires:
  assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    wd_fire |=> CHIP_RESET_OUT ##0 ctrl_rd == 8'h30)
  else $error("watchdog expiry did not reset with 30h");
  a_timer_no_rst:
  assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    tmr_ovf |=> !CHIP_RESET_OUT && ovf_q && stat_q[`WDT_IRQ_TMR])
  else $error("interval overflow misbehaved");
  a_pd_osc_wait:
  assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    wd_fire && POWER_DOWN_IN |=> OSC_START_OUT && CHIP_RESET_OUT)
  else $error("oscillator restart not requested");
  a_one_write:
  assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    cfg_q && lock_q && !wd_fire |=> $stable(rate_q))
  else $error("second control write took effect");
  a_forced_bits:
  assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    cfg_q |-> ctrl_rd[`WDT_BIT_RUN] && !ctrl_rd[`WDT_BIT_CLKSEL])
  else $error("forced control bits wrong");
  a_feed_clears:
  assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    feed_ok && !expired && !wd_fire |=> !ovf_q)
  else $error("good feed did not clear overflow");
  a_bad_feed:
  assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    feed_bad && ovf_q && !wd_fire |=> ovf_q)
  else $error("wrong feed changed overflow flag");
  a_irq_level:
  assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    IRQ_OUT == |(stat_q & mask_q))
  else $error("interrupt level wrong");
endmodule // wdt_top
`default_nettype wire

//--- bench/wdt_osc_model.sv
// RC oscillator and main oscillator model around the watchdog
`timescale 1ns/1ps
`default_nettype none
module wdt_osc_model #(
  parameter int TICK_DIV   = 8,
  parameter int STABLE_DLY = 20
) (
  input  wire logic clk_in,
  input  wire logic power_down_in,
  input  wire logic osc_start_in,
  output logic      rc_tick_out,
  output logic      osc_stable_out
);
  int   tick_cnt_q = 0;
  int   wake_cnt_q = 0;
  logic osc_run_q  = 1'b0;
  // RC ticks run free, even with the CPU clock stopped
  always_ff @(posedge clk_in) begin
    tick_cnt_q <= (tick_cnt_q == TICK_DIV - 1) ? 0 : tick_cnt_q + 1;
  end
  assign rc_tick_out = (tick_cnt_q == 0);
  // Main oscillator stops in power-down and needs a start-up delay
  always_ff @(posedge clk_in) begin
    wake_cnt_q <= osc_start_in ? wake_cnt_q + 1 : 0;
    if (osc_start_in && wake_cnt_q >= STABLE_DLY) begin
      osc_run_q <= 1'b1;
    end else if (!power_down_in) begin
      osc_run_q <= 1'b0;
    end
  end
  assign osc_stable_out = !power_down_in || osc_run_q;
endmodule // wdt_osc_model
`default_nettype wire

//--- bench/watchdog_interval_timer_test.sv
// Self-checking bench for the watchdog interval timer
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"
module watchdog_interval_timer_test;
  localparam logic [11:0] A_CTL  = {`WDT_IDX_CONTROL, 2'b00};
  localparam logic [11:0] A_FEED = {`WDT_IDX_FEED, 2'b00};
  localparam logic [11:0] A_STAT = {`WDT_IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_MASK = {`WDT_IDX_IRQ_MASK, 2'b00};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic        ack, strap = 1'b1, tick, pdn = 1'b0, stable;
  logic        chip_rst, osc_start, irq;
  logic [31:0] seed = 32'h0000f25d; // 62045
  logic [31:0] exp_q[$];
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          ticks = 0;
  int          n, r, i;

  always #50 clk = ~clk;

  wdt_top #(.TIMEOUT_BASE(16), .CNT_W(21)) wdt_top_inst (
    .CLK_IN(clk), .RESET_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat_w),
    .WB_DAT_OUT(dat_r), .WB_ACK_OUT(ack), .WD_ENABLE_CFG_BIT_IN(strap),
    .RC_TICK_IN(tick), .POWER_DOWN_IN(pdn), .OSC_STABLE_IN(stable),
    .CHIP_RESET_OUT(chip_rst), .OSC_START_OUT(osc_start), .IRQ_OUT(irq));

  wdt_osc_model wdt_osc_model_inst (
    .clk_in(clk), .power_down_in(pdn), .osc_start_in(osc_start),
    .rc_tick_out(tick), .osc_stable_out(stable));

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Read data is judged against the oldest note when ack shows
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      check(dat_r, exp_q.pop_front());
    end
  end

  // Ticks since the last timed feed
  always @(posedge clk) begin
    if (tick === 1'b1) ticks++;
  end

  // Hang guard
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end

  // ---------------------------------------------------------------
  // Drivers
  // ---------------------------------------------------------------
  function automatic logic [7:0] rnd_bad();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    // Never a valid feed byte, so it always breaks the pair
    return (seed[7:0] == 8'h1e || seed[7:0] == 8'he1) ? 8'h00 : seed[7:0];
  endfunction

  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    dat_w <= {24'h0, d};
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k == 20) begin
      n_mismatch++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask

  // Feed placed clear of a tick so the restart edge is unambiguous
  task automatic feed;
    int k;
    for (k = 0; k < 20 && tick !== 1'b1; k++) @(posedge clk);
    if (k == 20) begin
      n_mismatch++;
      end_sim();
    end
    wr(A_FEED, `WDT_FEED_FIRST);
    wr(A_FEED, `WDT_FEED_SECOND);
    ticks = 0;
  endtask

  task automatic wait_hi(input logic pick_irq, input int lim, output int c);
    for (c = 0; c < lim; c++) begin
      @(posedge clk);
      if ((pick_irq ? irq : chip_rst) === 1'b1) return;
    end
    n_mismatch++;
    end_sim();
  endtask

  // Counts reset cycles after the oscillator request has dropped
  task automatic hi_len(output int c);
    int k;
    c = 0;
    for (k = 0; k < 100 && chip_rst === 1'b1; k++) begin
      if (osc_start !== 1'b1) c++;
      @(posedge clk);
    end
    if (k == 100) begin
      n_mismatch++;
      end_sim();
    end
  endtask

  task automatic reset_dut(input logic s);
    strap <= s;
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    reset_dut(1'b1);
    rd(A_CTL, 32'h10);
    rd(12'h3fc, 32'h0);
    wr(A_CTL, 8'h08);
    rd(A_CTL, 32'h10);
    wr(A_CTL, 8'h07);
    rd(A_CTL, 32'h10);
    // One timeout per rate code; each watchdog reset reopens the write
    for (r = 0; r < 8; r++) begin
      wr(A_FEED, 8'h1e);
      rd(A_MASK, 32'h0);
      wr(A_FEED, 8'he1);
      wr(A_CTL, 8'(r));
      rd(A_CTL, 32'h10 | r);
      feed();
      if (r == 0) begin
        repeat (40) @(posedge clk);
        wr(A_FEED, 8'h1e);
        wr(A_FEED, rnd_bad());
        wr(A_FEED, 8'he1);
      end
      wait_hi(1'b0, 20000, n);
      check(32'(ticks), 32'(16 << r));
      hi_len(n);
      check(32'(n), 32'd10);
      rd(A_CTL, 32'h30);
    end
    // Timeout while powered down
    feed();
    pdn <= 1'b1;
    wait_hi(1'b0, 2000, n);
    check(32'(osc_start), 32'h1);
    hi_len(n);
    check(32'(n), 32'd10);
    pdn <= 1'b0;
    // Another reset source clears the count midway
    feed();
    repeat (80) @(posedge clk);
    reset_dut(1'b1);
    n = 0;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (chip_rst !== 1'b0) n++;
    end
    check(32'(n), 32'h0);
    // Interval timer mode
    reset_dut(1'b0);
    rd(A_CTL, 32'h00);
    wr(A_MASK, 8'h01);
    wr(A_CTL, 8'h10);
    wait_hi(1'b1, 400, n);
    check(32'(chip_rst), 32'h0);
    rd(A_CTL, 32'h30);
    wr(A_FEED, rnd_bad());
    rd(A_STAT, 32'h3);
    wr(A_STAT, 8'h03);
    rd(A_STAT, 32'h0);
    check(32'(irq), 32'h0);
    wr(A_MASK, 8'h00);
    n = 0;
    for (i = 0; i < 160; i++) begin
      @(posedge clk);
      if (irq !== 1'b0) n++;
    end
    check(32'(n), 32'h0);
    rd(A_STAT, 32'h1);
    // Run bit low stops the count
    wr(A_CTL, 8'h00);
    wr(A_STAT, 8'h03);
    wr(A_MASK, 8'h01);
    repeat (300) @(posedge clk);
    rd(A_STAT, 32'h0);
    // CPU clock over six: 96 cycles, where RC ticks would need 128
    // A feed first, since the stopped count kept its partial value
    wr(A_FEED, 8'h1e);
    wr(A_FEED, 8'he1);
    wr(A_CTL, 8'h18);
    wait_hi(1'b1, 400, n);
    check(32'(n >= 92 && n <= 106), 32'h1);
    wr(A_FEED, 8'h1e);
    wr(A_FEED, 8'he1);
    rd(A_CTL, 32'h18);
    end_sim();
  end
endmodule // watchdog_interval_timer_test
`default_nettype wire
